// ===== core/pbm_bus_if.sv
// Purpose: register bus between controller and device
// Assumes: both ends on clk_sys
// Notes: read data is valid the cycle after the read strobe
`timescale 1ns/1ps
interface pbm_bus_if;
  logic [2:0] addr;
  logic [1:0] be;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport dev (input addr, input be, input wr, input rd, input wdata, output rdata);
  modport host (output addr, output be, output wr, output rd, output wdata, input rdata);
endinterface : pbm_bus_if

// ===== core/pbm_device.sv
// Purpose: device end, command sequencing, packet number, result, queue ports, pointer
// Assumes: engine signals come from logic on clk_sys
// Notes: queue contents and the data fifos live in the engine outside
`timescale 1ns/1ps
module pbm_device
  import pbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  pbm_bus_if.dev bus,
  input wire logic alloc_done_in,
  input wire logic alloc_ok,
  input wire logic [PKT_W-1:0] alloc_pkt_in,
  input wire logic release_done,
  input wire logic rx_queue_empty_flag,
  input wire logic [PKT_W-1:0] rx_head,
  input wire logic tx_done_queue_empty_flag,
  input wire logic [PKT_W-1:0] tx_done_head,
  input wire logic tx_int_ack,
  input wire logic wfifo_pending,
  input wire logic data_step,
  input wire logic [1:0] data_size,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [PKT_W-1:0] cmd_packet,
  output logic receive_area_select,
  output logic [PKT_W-1:0] area_packet,
  output logic [PTR_W-1:0] area_addr,
  output logic read_mode,
  output logic prefetch,
  output logic early_underrun_detect_enable,
  output logic alloc_done_flag,
  output logic rx_pop,
  output logic tx_done_pop
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [PKT_W-1:0] packet_number_select;
    logic failed;
    logic [PKT_W-1:0] alloc_pkt;
    logic alloc_done;
    logic busy;
    logic [15:0] ptr;
    logic [15:0] rdata;
    logic cmd_v;
    logic [2:0] cmd;
    logic [PKT_W-1:0] cmd_pkt;
    logic prefetch;
    logic rx_pop;
    logic tx_pop;
    logic [PKT_W-1:0] area_pkt;
  } pbm_dev_type;

  pbm_dev_type st;
  pbm_dev_type next_st;

  function automatic logic [PTR_W-1:0] step_of(input logic [1:0] size);
    unique case (size)
      2'h0: return 11'h001;
      2'h1: return 11'h002;
      default: return 11'h004;
    endcase
  endfunction : step_of

  logic cmd_wr;
  logic pkt_wr;
  logic ptr_lo_wr;
  logic ptr_hi_wr;
  pbm_cmd_type cmd_in;

  assign cmd_wr = bus.wr && bus.addr == word_of(OFS_CMD) && bus.be[0];
  assign pkt_wr = bus.wr && bus.addr == word_of(OFS_PKT) && bus.be[0];
  assign ptr_lo_wr = bus.wr && bus.addr == word_of(OFS_PTR) && bus.be[0];
  assign ptr_hi_wr = bus.wr && bus.addr == word_of(OFS_PTR) && bus.be[1];
  assign cmd_in = pbm_cmd_type'(bus.wdata[CMD_LSB +: 3]);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cmd_v = 1'b0;
    next_st.prefetch = 1'b0;
    next_st.rx_pop = 1'b0;
    next_st.tx_pop = tx_int_ack; // completion head leaves on transmit acknowledge [R13]
    // engine answers first, a new command in the same cycle overrides it
    if (alloc_done_in) begin
      if (alloc_ok) begin
        next_st.failed = 1'b0; // failed stays set until allocation satisfied [R8]
        next_st.alloc_done = 1'b1;
      end
      next_st.alloc_pkt = alloc_pkt_in; // latest allocated number [R10]
    end
    if (release_done) begin
      next_st.busy = 1'b0; // [R3]
    end
    if (cmd_wr) begin
      // flags change at the edge that ends the command write [R6]
      next_st.cmd_v = 1'b1;
      next_st.cmd = cmd_in;
      next_st.cmd_pkt = st.packet_number_select; // packet argument of the command [R7]
      unique case (cmd_in)
        CMD_ALLOC: begin
          next_st.failed = 1'b1; // [R6] [R8]
          next_st.alloc_done = 1'b0;
        end
        CMD_MMU_RESET: begin
          next_st.packet_number_select = '0; // [R7]
          next_st.failed = RST_FAILED; // [R8]
          next_st.alloc_done = 1'b0;
          next_st.busy = 1'b0;
        end
        CMD_REMOVE: begin
          next_st.rx_pop = 1'b1; // [R13]
        end
        CMD_REM_REL: begin
          next_st.rx_pop = 1'b1; // [R13]
          next_st.busy = 1'b1; // set wins over a release_done in this cycle [R3] [R6]
        end
        CMD_REL_PKT: begin
          next_st.busy = 1'b1; // [R3] [R6]
        end
        default: begin
        end
      endcase
    end
    if (pkt_wr && !(cmd_wr && cmd_in == CMD_MMU_RESET)) begin
      next_st.packet_number_select = bus.wdata[PKT_W-1:0]; // [R7]
    end
    // pointer: advance on each data access while the auto-increment bit is set, a host load takes precedence
    if (data_step && st.ptr[PTR_AUTO]) begin
      next_st.ptr[PTR_W-1:0] = st.ptr[PTR_W-1:0] + step_of(data_size); // [R15]
    end
    if (ptr_lo_wr) begin
      next_st.ptr[7:0] = bus.wdata[7:0];
    end
    if (ptr_hi_wr) begin
      // the high byte completes a load, so byte loads end with it
      next_st.ptr[15:8] = bus.wdata[15:8];
      next_st.ptr[PTR_PEND] = 1'b0;
      next_st.prefetch = bus.wdata[PTR_READ]; // read load starts a prefetch [R16]
    end
    next_st.area_pkt = next_st.ptr[PTR_RCV] ? rx_head : next_st.packet_number_select; // [R14]
    // read answer, registered; unmapped words read as zero
    if (bus.rd) begin
      unique case (bus.addr)
        word_of(OFS_CMD): next_st.rdata = {15'h0000, st.busy}; // [R3]
        word_of(OFS_PKT): begin
          next_st.rdata = {st.failed, 1'b0, st.alloc_pkt, 2'h0, st.packet_number_select}; // [R8] [R10]
        end
        word_of(OFS_QUE): begin
          next_st.rdata = {rx_queue_empty_flag, 1'b0, rx_head,
                           tx_done_queue_empty_flag, 1'b0, tx_done_head}; // [R12] [R13]
        end
        word_of(OFS_PTR): begin
          // address of the last host access, not of the prefetch [R17]
          next_st.rdata = st.ptr;
          next_st.rdata[PTR_PEND] = wfifo_pending; // [R18]
        end
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.failed <= RST_FAILED; // [R8]
      st.ptr <= RST_PTR;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus.rdata = st.rdata;
  assign cmd_valid = st.cmd_v;
  assign cmd_code = st.cmd;
  assign cmd_packet = st.cmd_pkt;
  assign receive_area_select = st.ptr[PTR_RCV]; // [R14]
  assign area_packet = st.area_pkt;
  assign area_addr = st.ptr[PTR_W-1:0];
  assign read_mode = st.ptr[PTR_READ]; // [R16]
  assign prefetch = st.prefetch;
  assign early_underrun_detect_enable = st.ptr[PTR_EARLY_UNDERRUN_DETECT_ENABLE]; // [R22]
  assign alloc_done_flag = st.alloc_done;
  assign rx_pop = st.rx_pop;
  assign tx_done_pop = st.tx_pop;
endmodule : pbm_device

// ===== core/pbm_host.sv
// Purpose: controller end, axi4-lite slave that issues guarded accesses to the device
// Assumes: software writes ACCESS, polls STATUS
// Notes: a request that would break command sequencing is refused, not queued
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pbm_host
  import pbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  pbm_bus_if.host bus
);
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ISSUE = 2'h1, S_DONE = 2'h2, S_SETTLE = 2'h3} pbm_hst_type;
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    pbm_hst_type fsm;
    logic [2:0] addr;
    logic [1:0] be;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] last_rd;
    logic refused;
    logic [2:0] wait_cnt;
    logic alloc_pend;
    logic rel4;
    logic rel5;
    logic ptr_clear;
    logic lo_written;
    logic [1:0] lo_bits;
  } pbm_host_type;

  pbm_host_type st;
  pbm_host_type next_st;
  logic [2:0] a_word;
  logic [1:0] a_be;
  logic a_wr;
  logic [15:0] a_data;
  logic refuse;

  assign a_word = st.w_data[2:0];
  assign a_be = st.w_data[ACC_BE_LSB +: 2];
  assign a_wr = st.w_data[ACC_WR_BIT];
  assign a_data = st.w_data[31:16];

  // ------------------------------------------------------------
  // sequencing guards
  // ------------------------------------------------------------
  always_comb begin
    refuse = 1'b0;
    if (a_wr && a_word == word_of(OFS_CMD) && a_be[0]) begin
      unique case (pbm_cmd_type'(a_data[CMD_LSB +: 3]))
        CMD_ALLOC: refuse = st.alloc_pend; // [R1]
        CMD_REM_REL, CMD_REL_PKT: refuse = st.rel4 || st.rel5; // [R2]
        CMD_REMOVE: refuse = st.rel4; // [R5]
        default: refuse = 1'b0;
      endcase
    end
    if (a_wr && a_word == word_of(OFS_PKT) && a_be[0] && st.rel5) begin
      refuse = 1'b1; // [R4]
    end
    if (a_wr && a_word == word_of(OFS_PTR) && a_be[1]) begin
      if (!st.ptr_clear) begin
        refuse = 1'b1; // [R18]
      end
      if (!a_be[0] && !st.lo_written) begin
        refuse = 1'b1; // [R20]
      end
      if (!a_data[PTR_AUTO] && (a_be[0] ? a_data[1:0] : st.lo_bits) != 2'h0) begin
        refuse = 1'b1; // [R21]
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (s_axi_awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_addr != AXI_ACCESS) begin
        next_st.bresp = RESP_SLVERR;
      end else if (st.fsm != S_IDLE || refuse) begin
        next_st.refused = 1'b1;
      end else begin
        next_st.refused = 1'b0;
        next_st.fsm = S_ISSUE;
        next_st.addr = a_word;
        next_st.be = a_be;
        next_st.wr = a_wr;
        next_st.wdata = a_data;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = (s_axi_araddr == AXI_STATUS) ? RESP_OKAY : RESP_SLVERR;
      next_st.rdata = '0;
      if (s_axi_araddr == AXI_STATUS) begin
        next_st.rdata = {st.last_rd, 14'h0000, st.refused, st.fsm != S_IDLE};
      end
    end
    unique case (st.fsm)
      S_IDLE: begin
      end
      S_ISSUE: next_st.fsm = S_DONE;
      S_DONE: begin
        next_st.fsm = S_IDLE;
        if (!st.wr) begin
          next_st.last_rd = bus.rdata;
          if (st.addr == word_of(OFS_PKT) && !bus.rdata[8 + FLAG_BIT]) begin
            next_st.alloc_pend = 1'b0; // [R1] [R9]
          end
          if (st.addr == word_of(OFS_CMD) && !bus.rdata[BUSY_BIT]) begin
            next_st.rel4 = 1'b0; // [R5]
            next_st.rel5 = 1'b0; // [R4]
          end
          if (st.addr == word_of(OFS_PTR)) begin
            next_st.ptr_clear = !bus.rdata[PTR_PEND]; // [R18]
          end
        end else if (st.addr == word_of(OFS_CMD) && st.be[0]) begin
          unique case (pbm_cmd_type'(st.wdata[CMD_LSB +: 3]))
            CMD_ALLOC: next_st.alloc_pend = 1'b1; // [R1]
            CMD_REM_REL: next_st.rel4 = 1'b1; // [R2]
            CMD_REL_PKT: next_st.rel5 = 1'b1; // [R2]
            CMD_MMU_RESET: next_st.alloc_pend = 1'b0;
            default: begin
            end
          endcase
        end else if (st.addr == word_of(OFS_PTR)) begin
          next_st.lo_written = st.be == 2'h1; // [R20]
          if (st.be[0]) begin
            next_st.lo_bits = st.wdata[1:0];
          end
          if (st.be[1]) begin
            // data fifo must be seen empty again before the next load
            next_st.ptr_clear = 1'b0; // [R18]
            next_st.fsm = S_SETTLE;
            next_st.wait_cnt = 3'(PTR_SETTLE_CYC - 1); // [R19]
          end
        end
      end
      S_SETTLE: begin
        // no access until the read fifo has had time to fill [R19]
        next_st.wait_cnt = st.wait_cnt - 3'h1;
        if (st.wait_cnt == 3'h0) begin
          next_st.fsm = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.ptr_clear <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign bus.addr = st.addr;
  assign bus.be = st.be;
  assign bus.wdata = st.wdata;
  assign bus.wr = st.fsm == S_ISSUE && st.wr;
  assign bus.rd = st.fsm == S_ISSUE && !st.wr;
endmodule : pbm_host

// ===== core/pbm_pkg.sv
// Purpose: shared constants and types of the packet buffer manager host access block
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: register bus carries 16-bit words, word index is byte offset / 2
//
// Behaviour
// R1 - host holds allocate until previous allocation completes
// R2 - host holds release while release still busy
// R3 - busy flag at command bit 0
// R6 - busy and failed set after command write
// R4 - after release-specific, packet number held until idle
// R5 - after remove-release, no remove until idle
// R7 - packet number register, cleared by manager reset
// R8 - allocation result updates, failed defaults high
// R9 - software polls alloc done, then reads result
// R10 - allocation result reports latest packet number
// R11 - software copies allocated number unmasked
// R12 - queue ports: receive high, completion low
// R13 - heads valid while not empty, popped
// R14 - receive select picks area and packet
// R15 - auto-increment by one, two or four
// R16 - direction bit, read load starts prefetch
// R17 - pointer reads back last accessed address
// R18 - write fifo pending flag, host waits clear
// R19 - host waits 370 ns after pointer load
// R20 - byte pointer writes: low byte first
// R21 - no auto-increment needs dword aligned pointer
// R22 - control bit enables early underrun detection
package pbm_pkg;
  // ------------------------------------------------------------
  // register map of the device, byte offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_PKT = 4'h2;
  localparam logic [3:0] OFS_ARR = 4'h3;
  localparam logic [3:0] OFS_QUE = 4'h4;
  localparam logic [3:0] OFS_PTR = 4'h6;
  localparam int PKT_W = 6;
  localparam int FLAG_BIT = 7;
  localparam int BUSY_BIT = 0;
  localparam int CMD_LSB = 5;
  localparam int PTR_RCV = 15;
  localparam int PTR_AUTO = 14;
  localparam int PTR_READ = 13;
  localparam int PTR_EARLY_UNDERRUN_DETECT_ENABLE = 12;
  localparam int PTR_PEND = 11;
  localparam int PTR_W = 11;
  localparam logic RST_FAILED = 1'h1;
  localparam logic [15:0] RST_PTR = 16'h0000;
  typedef enum logic [2:0] {
    CMD_NOOP = 3'h0, CMD_ALLOC = 3'h1, CMD_MMU_RESET = 3'h2, CMD_REMOVE = 3'h3,
    CMD_REM_REL = 3'h4, CMD_REL_PKT = 3'h5, CMD_ENQUEUE = 3'h6, CMD_TX_RESET = 3'h7
  } pbm_cmd_type;
  // ------------------------------------------------------------
  // controller registers on the axi side
  // ------------------------------------------------------------
  localparam logic [3:0] AXI_ACCESS = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam int ACC_BE_LSB = 4;
  localparam int ACC_WR_BIT = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PTR_SETTLE_NS = 370;
  localparam int PTR_SETTLE_CYC = (PTR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [2:0] word_of(input logic [3:0] ofs);
    return ofs[3:1];
  endfunction : word_of
endpackage : pbm_pkg

// ===== test/pbm_asserts.sv
// Purpose: concurrent checks on the register bus between controller and device
// Assumes: one clock, synchronous active-low reset
// Notes: busy and failed are mirrored from bus writes and engine pulses
`timescale 1ns/1ps
module pbm_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [1:0] be,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic rx_pop,
  input wire logic tx_done_pop,
  input wire logic prefetch,
  input wire logic release_done,
  input wire logic alloc_done_in,
  input wire logic alloc_ok,
  input wire logic tx_int_ack
);
  typedef struct packed {logic busy; logic fail;} pbm_mdl_type;
  pbm_mdl_type mdl;
  pbm_mdl_type next_mdl;
  logic cmd_wr;
  logic [2:0] cmd;
  assign cmd_wr = wr && addr == 3'h0 && be[0];
  assign cmd = wdata[7:5];
  // ------
  // reference flags, a new command wins over a completion
  // ------
  always_comb begin
    next_mdl = mdl;
    if (release_done || (cmd_wr && cmd == 3'h2)) next_mdl.busy = 1'b0;
    if (cmd_wr && (cmd == 3'h4 || cmd == 3'h5)) next_mdl.busy = 1'b1;
    if (alloc_done_in && alloc_ok) next_mdl.fail = 1'b0;
    if (cmd_wr && (cmd == 3'h1 || cmd == 3'h2)) next_mdl.fail = 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) mdl <= '{busy: 1'b0, fail: 1'b1};
    else mdl <= next_mdl;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------
  // properties
  // ------
  property p_cmd_issue;
    cmd_wr && cmd != 3'h0 |=> cmd_valid && cmd_code == $past(cmd);
  endproperty
  a_cmd_issue: assert property (p_cmd_issue) else $error("command write not issued");
  property p_cmd_cause;
    cmd_valid |-> $past(wr) && $past(addr) == 3'h0;
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("command without write");
  property p_busy_read;
    rd && addr == 3'h0 |=> rdata[0] == $past(mdl.busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy flag wrong");
  property p_failed_read;
    rd && addr == 3'h1 |=> rdata[15] == $past(mdl.fail);
  endproperty
  a_failed_read: assert property (p_failed_read) else $error("failed flag wrong");
  property p_rx_pop;
    cmd_wr && (cmd == 3'h3 || cmd == 3'h4) |=> rx_pop;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive head not removed");
  property p_tx_pop;
    tx_int_ack |=> tx_done_pop;
  endproperty
  a_tx_pop: assert property (p_tx_pop) else $error("completion head not removed");
  property p_prefetch;
    wr && addr == 3'h3 && be[1] && wdata[13] |=> prefetch;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("no prefetch on read load");
  property p_settle;
    wr && addr == 3'h3 && be[1] |=> !(wr || rd) [*4];
  endproperty
  a_settle: assert property (p_settle) else $error("access too soon after pointer load");
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  c_release: cover property (cmd_wr && cmd == 3'h4);
  c_prefetch: cover property (prefetch);
  c_alloc: cover property (alloc_done_in && alloc_ok);
  c_txpop: cover property (tx_done_pop);
endmodule : pbm_asserts

// ===== test/testbench.sv
// Purpose: self-checking bench, controller and device joined by the register bus
// Assumes: 10 MHz clock, reset held 4 cycles
// Notes: each device access is an ACCESS write, then STATUS polled until idle
`timescale 1ns/1ps
module testbench
  import pbm_pkg::*;
;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, data_size;
  logic alloc_done_in, alloc_ok, release_done, rx_queue_empty_flag, tx_done_queue_empty_flag;
  logic tx_int_ack, wfifo_pending, data_step, cmd_valid, receive_area_select, read_mode, prefetch;
  logic early_underrun_detect_enable, alloc_done_flag, rx_pop, tx_done_pop;
  logic [2:0] cmd_code;
  logic [PKT_W-1:0] alloc_pkt_in, rx_head, tx_done_head, cmd_packet, area_packet;
  logic [PTR_W-1:0] area_addr;
  int n_errors = 0;
  int n_tests = 0;
  int i;
  typedef struct {logic [2:0] w; logic [1:0] be; logic wr; logic [15:0] d; logic [31:0] m; logic [31:0] e;} pbm_row_type;
  pbm_row_type rows [6] = '{
    '{3'h1, 2'h1, 1'b1, 16'h0005, 32'h00000002, 32'h00000000},
    '{3'h1, 2'h3, 1'b0, 16'h0000, 32'hffff0002, 32'h80050000},
    '{3'h2, 2'h3, 1'b0, 16'h0000, 32'hffff0002, 32'h2a110000},
    '{3'h3, 2'h3, 1'b1, 16'h9010, 32'h00000002, 32'h00000000},
    '{3'h3, 2'h3, 1'b0, 16'h0000, 32'hffff0002, 32'h90100000},
    '{3'h4, 2'h3, 1'b0, 16'h0000, 32'hffff0002, 32'h00000000}};
  pbm_bus_if i_pbm_bus_if ();
  pbm_host i_pbm_host (.*, .bus(i_pbm_bus_if));
  pbm_device i_pbm_device (.*, .bus(i_pbm_bus_if));
  pbm_asserts i_pbm_asserts (.clk_sys, .rst_n, .addr(i_pbm_bus_if.addr), .be(i_pbm_bus_if.be),
    .wr(i_pbm_bus_if.wr), .rd(i_pbm_bus_if.rd), .wdata(i_pbm_bus_if.wdata), .rdata(i_pbm_bus_if.rdata),
    .cmd_valid, .cmd_code, .rx_pop, .tx_done_pop, .prefetch, .release_done, .alloc_done_in, .alloc_ok,
    .tx_int_ack);
  always #50 clk_sys = ~clk_sys;
  // ------
  // tasks
  // ------
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic tmo;
    n_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    end_sim();
  endtask : tmo
  // both tasks are entered just after a rising edge; ready is sampled on the low phase
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic ta;
    logic tw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (s_axi_bvalid === 1'b1) break;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    if (k == 40) tmo();
    r = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ta;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (s_axi_rvalid === 1'b1) break;
      ta = s_axi_arvalid && s_axi_arready;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    if (k == 40) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd
  task automatic acc(input logic [2:0] w, input logic [1:0] be, input logic wr, input logic [15:0] d);
    int k;
    axi_wr(AXI_ACCESS, {d, 7'h00, wr, 2'h0, be, 1'h0, w}, rsp);
    for (k = 0; k < 20; k++) begin
      axi_rd(AXI_STATUS, st, rsp);
      if (st[ST_BUSY] === 1'b0) break;
    end
    if (k == 20) tmo();
  endtask : acc
  task automatic rd_w(input logic [2:0] w);
    acc(w, 2'h3, 1'b0, 16'h0000);
  endtask : rd_w
  task automatic pulse(input int s);
    @(posedge clk_sys);
    case (s)
      0: alloc_done_in <= 1'b1;
      1: release_done <= 1'b1;
      default: tx_int_ack <= 1'b1;
    endcase
    @(posedge clk_sys);
    {alloc_done_in, release_done, tx_int_ack} <= 3'h0;
    @(posedge clk_sys);
  endtask : pulse
  // ------
  // main sequence
  // ------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hf, 32'h00000000};
    {alloc_done_in, alloc_ok, release_done, tx_int_ack, wfifo_pending, data_step} = 6'h00;
    {rx_queue_empty_flag, tx_done_queue_empty_flag, data_size, alloc_pkt_in} = 10'h000;
    {rx_head, tx_done_head} = {6'h2a, 6'h11};
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_w(3'h3);
    `CHK(st[31:16], RST_PTR)
    for (i = 0; i < 6; i++) begin
      acc(rows[i].w, rows[i].be, rows[i].wr, rows[i].d);
      `CHK(st & rows[i].m, rows[i].e)
    end
    `CHK({receive_area_select, early_underrun_detect_enable, area_packet, area_addr}, 19'h75010)
    acc(3'h3, 2'h3, 1'b1, 16'h0010);
    `CHK({receive_area_select, area_packet}, 7'h05)
    {alloc_ok, alloc_pkt_in} <= 7'h63;
    acc(3'h0, 2'h1, 1'b1, 16'h0020);
    acc(3'h0, 2'h1, 1'b1, 16'h0020);
    `CHK(st[ST_REFUSED], 1'b1)
    pulse(0);
    `CHK(alloc_done_flag, 1'b1)
    rd_w(3'h1);
    `CHK(st[31:16], 16'h2305)
    acc(3'h0, 2'h1, 1'b1, 16'h0020);
    `CHK(st[ST_REFUSED], 1'b0)
    alloc_ok <= 1'b0;
    pulse(0);
    rd_w(3'h1);
    `CHK(st[31], 1'b1)
    acc(3'h0, 2'h1, 1'b1, 16'h0080);
    rd_w(3'h0);
    `CHK(st[17:16], 2'h1)
    acc(3'h0, 2'h1, 1'b1, 16'h0060);
    `CHK(st[ST_REFUSED], 1'b1)
    acc(3'h0, 2'h1, 1'b1, 16'h00a0);
    `CHK(st[ST_REFUSED], 1'b1)
    pulse(1);
    rd_w(3'h0);
    `CHK(st[16], 1'b0)
    acc(3'h0, 2'h1, 1'b1, 16'h00a0);
    `CHK(cmd_packet, 6'h05)
    acc(3'h1, 2'h1, 1'b1, 16'h0009);
    `CHK(st[ST_REFUSED], 1'b1)
    pulse(1);
    rd_w(3'h0);
    acc(3'h1, 2'h1, 1'b1, 16'h0009);
    `CHK(st[ST_REFUSED], 1'b0)
    acc(3'h0, 2'h1, 1'b1, 16'h0040);
    rd_w(3'h1);
    `CHK({st[31], st[23:16]}, 9'h100)
    rd_w(3'h3);
    acc(3'h3, 2'h3, 1'b1, 16'h6000);
    `CHK(read_mode, 1'b1)
    for (i = 0; i < 3; i++) begin
      data_step <= 1'b1;
      data_size <= 2'(i);
      @(posedge clk_sys);
      data_step <= 1'b0;
      @(posedge clk_sys);
    end
    rd_w(3'h3);
    `CHK(st[31:16], 16'h6007)
    wfifo_pending <= 1'b1;
    rd_w(3'h3);
    `CHK(st[27], 1'b1)
    acc(3'h3, 2'h3, 1'b1, 16'h4000);
    `CHK(st[ST_REFUSED], 1'b1)
    wfifo_pending <= 1'b0;
    rd_w(3'h3);
    acc(3'h3, 2'h3, 1'b1, 16'h0002);
    `CHK(st[ST_REFUSED], 1'b1)
    acc(3'h3, 2'h1, 1'b1, 16'h0034);
    acc(3'h3, 2'h2, 1'b1, 16'h4100);
    `CHK({st[ST_REFUSED], area_addr}, 12'h134)
    pulse(2);
    axi_wr(4'h8, 32'h00000000, rsp);
    `CHK(rsp, RESP_SLVERR)
    axi_rd(4'hc, st, rsp);
    `CHK(rsp, RESP_SLVERR)
    // second reset mid-run: the allocation result must fall back to its reset state
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_w(3'h1);
    `CHK(st[31:16], 16'h8000)
    end_sim();
  end
endmodule : testbench
